/* include/rftxm_cfg.svh */
/*
 Register map and reset values of the transmit mode configuration bank.
 Assumes: included by its bare name; word registers on a 32-bit bus.
*/
`ifndef RFTXM_CFG_SVH
`define RFTXM_CFG_SVH

// Register indices; byte address is four times the index
`define RFTXM_IDX_RSVD_A    6'h0f
`define RFTXM_IDX_RSVD_B    6'h10
`define RFTXM_IDX_MODE      6'h11
`define RFTXM_IDX_TXMODE    6'h12
`define RFTXM_IDX_IRQ_STS   6'h20
`define RFTXM_IDX_IRQ_CLR   6'h21
`define RFTXM_IDX_IRQ_EN    6'h22

// Reset values
`define RFTXM_RST_RSVD      8'h00
`define RFTXM_RST_MODE      8'h3f
`define RFTXM_RST_TXMODE    8'h00

// General mode fields
`define RFTXM_MODE_MSB      7
`define RFTXM_MODE_WAITRF   5
`define RFTXM_MODE_POL      3
`define RFTXM_MODE_PRE_HI   1
`define RFTXM_MODE_PRE_LO   0
`define RFTXM_MODE_MASK     8'hab

// Transmit mode fields
`define RFTXM_TX_CRC        7
`define RFTXM_TX_SPD_HI     6
`define RFTXM_TX_SPD_LO     4
`define RFTXM_TX_INV        3
`define RFTXM_TX_MASK       8'hf8

// Standalone CRC start values
`define RFTXM_PRESET_0      16'h0000
`define RFTXM_PRESET_1      16'h6363
`define RFTXM_PRESET_2      16'ha671
`define RFTXM_PRESET_3      16'hffff

// Interrupt status bits
`define RFTXM_IRQ_ENV       0
`define RFTXM_IRQ_TXBLK     1

`endif

/* include/rftxm_pkg.sv */
/*
 Types of the transmit mode configuration bank.
 Assumes: nothing beyond a SystemVerilog compiler.
*/
package rftxm_pkg;

	typedef enum logic [1:0] {
		RFTXM_BUS_IDLE = 2'b01,
		RFTXM_BUS_ACK  = 2'b10
	} rftxm_bus_e;

	typedef enum logic [2:0] {
		RFTXM_RATE_106 = 3'h0,
		RFTXM_RATE_212 = 3'h1,
		RFTXM_RATE_424 = 3'h2,
		RFTXM_RATE_848 = 3'h3
	} rftxm_rate_e;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} rftxm_avreq_s;

	// Avalon-MM answer to the master
	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} rftxm_avrsp_s;

	// Settings presented to the transmit and CRC logic
	typedef struct packed {
		logic        crc_bit_order_msb;
		logic [15:0] crc_start_value;
		logic        tx_needs_field;
		logic        envelope_in_polarity;
		logic        tx_crc_append_en;
		logic [2:0]  tx_bit_rate_sel;
		logic        tx_modulation_invert;
	} rftxm_cfg_s;

	// Whole state of the bank
	typedef struct packed {
		rftxm_bus_e  bus;
		logic [31:0] rdata;
		logic [7:0]  mode;
		logic [7:0]  txmode;
		logic [1:0]  sts;
		logic [1:0]  ien;
		logic        irq;
		logic        evt;
		logic        env_n;
		logic        tx_start;
		logic [15:0] crc_res;
		rftxm_cfg_s  cfg;
	} rftxm_state_s;

endpackage

/* hdl/rftxm_regs.sv */
/*
 Transmit mode configuration bank: Avalon-MM slave holding the general
 and transmit mode registers, two reserved slots, interrupt registers
 and the derived settings for the CRC unit and the transmitter.
 Assumes: one clock, inputs synchronous to clk, master keeps Avalon rules.
*/
// Behaviour
// [R1] Slots 0Fh and 10h reserved, read zero
// [R2] General mode resets 3Fh, bits 6,4,2 reserved
// [R3] MSB-first CRC, both result bytes bit reversed
// [R4] Bit order ignored during RF communication
// [R5] Transmitter starts only while field generated; code enforces this only while mode bit 5 (WAITRF) is set
// [R6] Polarity bit selects envelope pin active level
// [R7] Polarity change raises envelope activity event
// [R8] Preset field picks standalone CRC start value
// [R9] RF communication uses automatic CRC preset
// [R10] Transmit mode resets 00h, bits 2-0 reserved
// [R11] Transmit CRC enable appends generated CRC
// [R12] CRC append forced on above 106 kBd
// [R13] Speed field selects rate, 1xx reserved
// [R14] Invert bit inverts transmit modulation
// [R15] Reserved bits and addresses ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "rftxm_cfg.svh"

module rftxm_regs
	import rftxm_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Avalon-MM slave
	input  wire rftxm_avreq_s av_req,
	output var  rftxm_avrsp_s av_rsp,
	// Transmit and CRC context
	input  wire logic         rf_comm_active,
	input  wire logic         rf_field_on,
	input  wire logic [15:0]  auto_crc_preset,
	input  wire logic [15:0]  crc_raw_result,
	input  wire logic         tx_start_req,
	input  wire logic         envelope_input_pin,
	// Derived settings and events
	output var  rftxm_cfg_s   cfg,
	output logic [15:0]       crc_result_regs,
	output logic              tx_start,
	output logic              envelope_n,
	output logic              envelope_activity_event,
	output logic              irq
);

	rftxm_state_s state_r;
	rftxm_state_s state_nxt;

	logic       req;
	logic       take;
	logic [5:0] idx;
	logic       aligned;
	logic       wr_lo;
	logic [7:0] wbyte;
	logic [7:0] mode_w;
	logic [1:0] sts_set;

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	function automatic logic [15:0] preset_of(input logic [1:0] sel);
		logic [15:0] v;
		v = `RFTXM_PRESET_0;
		unique case (sel)
			2'h0: v = `RFTXM_PRESET_0;
			2'h1: v = `RFTXM_PRESET_1;
			2'h2: v = `RFTXM_PRESET_2;
			2'h3: v = `RFTXM_PRESET_3;
		endcase
		return v;
	endfunction

	assign req     = av_req.read | av_req.write;
	assign take    = req && (state_r.bus == RFTXM_BUS_ACK);
	assign idx     = av_req.address[7:2];
	assign aligned = (av_req.address[1:0] == 2'h0);
	assign wr_lo   = take && av_req.write && aligned && av_req.byteenable[0];
	assign wbyte   = av_req.writedata[7:0];

	always_comb begin
		state_nxt = state_r;
		mode_w    = state_r.mode;
		sts_set   = 2'h0;
		state_nxt.evt = 1'b0;

		// One wait cycle, then the answer for one cycle
		unique case (state_r.bus)
			RFTXM_BUS_IDLE: begin
				if (req) begin
					state_nxt.bus = RFTXM_BUS_ACK;
				end
			end
			RFTXM_BUS_ACK: begin
				state_nxt.bus = RFTXM_BUS_IDLE;
			end
			default: begin
				state_nxt.bus = RFTXM_BUS_IDLE;
			end
		endcase

		// Read data prepared while the master waits
		state_nxt.rdata = 32'h0000_0000; // [R1] [R15]
		if (av_req.read && aligned && state_r.bus == RFTXM_BUS_IDLE) begin
			unique case (idx)
				`RFTXM_IDX_MODE:    state_nxt.rdata[7:0] = state_r.mode & `RFTXM_MODE_MASK;
				`RFTXM_IDX_TXMODE:  state_nxt.rdata[7:0] = state_r.txmode & `RFTXM_TX_MASK;
				`RFTXM_IDX_IRQ_STS: state_nxt.rdata[1:0] = state_r.sts;
				`RFTXM_IDX_IRQ_EN:  state_nxt.rdata[1:0] = state_r.ien;
				default:            state_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Register writes; reserved bits stay zero
		if (wr_lo) begin
			unique case (idx)
				`RFTXM_IDX_MODE: begin
					mode_w = wbyte & `RFTXM_MODE_MASK; // [R2] [R15]
				end
				`RFTXM_IDX_TXMODE: begin
					state_nxt.txmode[`RFTXM_TX_CRC] = wbyte[`RFTXM_TX_CRC];
					state_nxt.txmode[`RFTXM_TX_INV] = wbyte[`RFTXM_TX_INV];
					// Reserved rate codes keep the previous rate
					if (!wbyte[`RFTXM_TX_SPD_HI]) begin // [R13]
						state_nxt.txmode[6:4] = wbyte[6:4];
					end
					state_nxt.txmode[2:0] = 3'h0; // [R10] [R15]
				end
				`RFTXM_IDX_IRQ_EN: begin
					state_nxt.ien = wbyte[1:0];
				end
				default: begin
				end
			endcase
		end
		state_nxt.mode = mode_w;

		// Polarity change is an envelope activity event
		if (mode_w[`RFTXM_MODE_POL] != state_r.mode[`RFTXM_MODE_POL]) begin // [R7]
			state_nxt.evt = 1'b1;
			sts_set[`RFTXM_IRQ_ENV] = 1'b1;
		end

		// Transmitter start gated by the field while the WAITRF mode bit is set
		state_nxt.tx_start = tx_start_req
			&& (!state_r.mode[`RFTXM_MODE_WAITRF] || rf_field_on); // [R5]
		sts_set[`RFTXM_IRQ_TXBLK] = tx_start_req && !state_nxt.tx_start;

		// Sticky status, set wins over clear
		if (wr_lo && idx == `RFTXM_IDX_IRQ_CLR) begin
			state_nxt.sts = state_r.sts & ~wbyte[1:0];
		end
		state_nxt.sts = state_nxt.sts | sts_set;
		state_nxt.irq = |(state_nxt.sts & state_nxt.ien);

		// Internal envelope is active low either way
		state_nxt.env_n = state_r.mode[`RFTXM_MODE_POL]
			? ~envelope_input_pin : envelope_input_pin; // [R6]

		// Settings for the CRC unit
		state_nxt.cfg.crc_bit_order_msb = state_r.mode[`RFTXM_MODE_MSB]
			&& !rf_comm_active; // [R3] [R4]
		state_nxt.cfg.crc_start_value = rf_comm_active ? auto_crc_preset // [R9]
			: preset_of(state_r.mode[1:0]); // [R8]
		state_nxt.crc_res = state_nxt.cfg.crc_bit_order_msb
			? {rev8(crc_raw_result[15:8]), rev8(crc_raw_result[7:0])} // [R3]
			: crc_raw_result;

		// Settings for the transmitter
		state_nxt.cfg.tx_needs_field       = state_r.mode[`RFTXM_MODE_WAITRF];
		state_nxt.cfg.envelope_in_polarity = state_r.mode[`RFTXM_MODE_POL];
		state_nxt.cfg.tx_crc_append_en = state_r.txmode[`RFTXM_TX_CRC] // [R11]
			|| (state_r.txmode[6:4] != RFTXM_RATE_106); // [R12]
		state_nxt.cfg.tx_bit_rate_sel      = state_r.txmode[6:4]; // [R13]
		state_nxt.cfg.tx_modulation_invert = state_r.txmode[`RFTXM_TX_INV]; // [R14]
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r.bus      <= RFTXM_BUS_IDLE;
			state_r.rdata    <= 32'h0000_0000;
			state_r.mode     <= `RFTXM_RST_MODE; // [R2]
			state_r.txmode   <= `RFTXM_RST_TXMODE; // [R10]
			state_r.sts      <= 2'h0;
			state_r.ien      <= 2'h0;
			state_r.irq      <= 1'b0;
			state_r.evt      <= 1'b0;
			state_r.env_n    <= 1'b1;
			state_r.tx_start <= 1'b0;
			state_r.crc_res  <= 16'h0000;
			state_r.cfg      <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign av_rsp.readdata         = state_r.rdata;
	assign av_rsp.waitrequest      = (state_r.bus != RFTXM_BUS_ACK);
	assign cfg                     = state_r.cfg;
	assign crc_result_regs         = state_r.crc_res;
	assign tx_start                = state_r.tx_start;
	assign envelope_n              = state_r.env_n;
	assign envelope_activity_event = state_r.evt;
	assign irq                     = state_r.irq;

	// Checks
	sequence s_pol_write;
		wr_lo && idx == `RFTXM_IDX_MODE
			&& wbyte[`RFTXM_MODE_POL] != state_r.mode[`RFTXM_MODE_POL];
	endsequence

	sequence s_pol_seen;
		envelope_activity_event ##1 state_r.sts[`RFTXM_IRQ_ENV];
	endsequence

	AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
		(take && av_req.read && (idx == `RFTXM_IDX_RSVD_A || idx == `RFTXM_IDX_RSVD_B))
		|-> av_rsp.readdata == 32'h0000_0000)
		else $error("reserved slot read not zero");

	AST_MODE_RSVD: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
		(take && av_req.read && idx == `RFTXM_IDX_MODE && aligned)
		|-> (av_rsp.readdata[6] == 1'b0 && av_rsp.readdata[4] == 1'b0
			&& av_rsp.readdata[2] == 1'b0 && av_rsp.readdata[31:8] == 24'h0))
		else $error("reserved mode bits not zero");

	AST_CRC_REV: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
		(state_r.mode[`RFTXM_MODE_MSB] && !rf_comm_active)
		|=> (crc_result_regs[15:8] == rev8($past(crc_raw_result[15:8]))
			&& crc_result_regs[7:0] == rev8($past(crc_raw_result[7:0]))))
		else $error("crc result not bit reversed");

	AST_ORDER_RF: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
		rf_comm_active |=> (!cfg.crc_bit_order_msb
			&& crc_result_regs == $past(crc_raw_result)))
		else $error("bit order used during rf communication");

	AST_TX_FIELD: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
		tx_start |-> $past(rf_field_on || !state_r.mode[`RFTXM_MODE_WAITRF]))
		else $error("transmitter started without field");

	AST_ENV_POL: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
		##1 envelope_n == ($past(state_r.mode[`RFTXM_MODE_POL])
			? !$past(envelope_input_pin) : $past(envelope_input_pin)))
		else $error("envelope polarity wrong");

	AST_POL_EVT: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
		s_pol_write |=> s_pol_seen)
		else $error("polarity change raised no event");

	AST_PRESET: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
		(!rf_comm_active && state_r.mode[1:0] == 2'h2 && $stable(state_r.mode))
		|=> cfg.crc_start_value == `RFTXM_PRESET_2)
		else $error("crc preset value wrong");

	AST_AUTO_PRE: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
		rf_comm_active |=> cfg.crc_start_value == $past(auto_crc_preset))
		else $error("automatic preset not used");

	AST_TX_RSVD: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
		state_r.txmode[2:0] == 3'h0 && state_r.mode[6] == 1'b0)
		else $error("reserved bits stored");

	AST_TX_CRC: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
		(state_r.txmode[6:4] != 3'h0 || state_r.txmode[`RFTXM_TX_CRC])
		|=> cfg.tx_crc_append_en)
		else $error("crc append off above 106 kBd");

	AST_RATE_RSVD: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
		(wr_lo && idx == `RFTXM_IDX_TXMODE && wbyte[6])
		|=> state_r.txmode[6:4] == $past(state_r.txmode[6:4]))
		else $error("reserved rate code accepted");

	AST_INV: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
		##1 cfg.tx_modulation_invert == $past(state_r.txmode[`RFTXM_TX_INV]))
		else $error("modulation invert not applied");

	AST_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r.sts[`RFTXM_IRQ_ENV] && state_r.ien[`RFTXM_IRQ_ENV]) |-> irq)
		else $error("enabled status without interrupt");

	sequence s_bus_req;
		req && state_r.bus == RFTXM_BUS_IDLE;
	endsequence

	sequence s_bus_answer;
		!av_rsp.waitrequest ##1 av_rsp.waitrequest;
	endsequence

	sequence s_tx_refused;
		tx_start_req && state_r.mode[`RFTXM_MODE_WAITRF] && !rf_field_on;
	endsequence

	sequence s_tx_blocked;
		!tx_start && state_r.sts[`RFTXM_IRQ_TXBLK];
	endsequence

	AST_BUS_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
		s_bus_req |=> s_bus_answer)
		else $error("bus answer not one cycle after request");

	AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
		av_rsp.waitrequest |-> av_rsp.readdata == 32'h0000_0000)
		else $error("read data outside answer cycle");

	AST_MODE_WR: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
		(wr_lo && idx == `RFTXM_IDX_MODE)
		|=> state_r.mode == ($past(wbyte) & `RFTXM_MODE_MASK))
		else $error("general mode write not stored");

	AST_TX_WR: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
		(wr_lo && idx == `RFTXM_IDX_TXMODE)
		|=> (state_r.txmode[`RFTXM_TX_CRC] == $past(wbyte[`RFTXM_TX_CRC])
			&& state_r.txmode[`RFTXM_TX_INV] == $past(wbyte[`RFTXM_TX_INV])))
		else $error("transmit mode write not stored");

	AST_RATE_WR: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
		(wr_lo && idx == `RFTXM_IDX_TXMODE && !wbyte[`RFTXM_TX_SPD_HI])
		|=> state_r.txmode[6:4] == $past(wbyte[6:4]))
		else $error("valid rate code not stored");

	AST_APPEND_106: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
		(state_r.txmode[6:4] == 3'h0)
		|=> cfg.tx_crc_append_en == $past(state_r.txmode[`RFTXM_TX_CRC]))
		else $error("crc append does not follow enable at 106 kBd");

	AST_TX_REFUSED: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
		s_tx_refused |=> s_tx_blocked)
		else $error("transmitter start not refused without field");

	AST_TX_NOREQ: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
		!tx_start_req |=> !tx_start)
		else $error("transmitter started without request");

	AST_CFG_FIELD: assert property (@(posedge clk) disable iff (!reset_n) // [R5] [R6]
		reset_n |=> (cfg.tx_needs_field == $past(state_r.mode[`RFTXM_MODE_WAITRF])
			&& cfg.envelope_in_polarity == $past(state_r.mode[`RFTXM_MODE_POL])))
		else $error("mode settings not presented");

	AST_EVT_CAUSE: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
		envelope_activity_event |-> $past(wr_lo && idx == `RFTXM_IDX_MODE
			&& wbyte[`RFTXM_MODE_POL] != state_r.mode[`RFTXM_MODE_POL]))
		else $error("envelope activity event without polarity change");

	AST_EVT_PULSE: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
		envelope_activity_event |=> !envelope_activity_event)
		else $error("envelope activity event longer than one cycle");

	AST_STS_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_lo && idx == `RFTXM_IDX_IRQ_CLR && wbyte[`RFTXM_IRQ_ENV])
		|=> !state_r.sts[`RFTXM_IRQ_ENV])
		else $error("status bit not cleared");

	AST_STS_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
		(state_r.sts[`RFTXM_IRQ_ENV]
			&& !(wr_lo && idx == `RFTXM_IDX_IRQ_CLR && wbyte[`RFTXM_IRQ_ENV]))
		|=> state_r.sts[`RFTXM_IRQ_ENV])
		else $error("status bit lost");

	AST_RSVD_WR: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
		(wr_lo && idx != `RFTXM_IDX_MODE && idx != `RFTXM_IDX_TXMODE
			&& idx != `RFTXM_IDX_IRQ_EN)
		|=> ($stable(state_r.mode) && $stable(state_r.txmode) && $stable(state_r.ien)))
		else $error("write to reserved address changed a register");

endmodule

`default_nettype wire

/* verification/tb_top.sv */
/*
 Self-checking bench of the transmit mode configuration bank.
 Assumes: rftxm_pkg compiled first; the bank answers each Avalon-MM access
 by dropping waitrequest for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import rftxm_pkg::*;
;
	logic         clk;
	logic         reset_n;
	rftxm_avreq_s av_req;
	rftxm_avrsp_s av_rsp;
	logic         rf_comm_active;
	logic         rf_field_on;
	logic [15:0]  auto_crc_preset;
	logic [15:0]  crc_raw_result;
	logic         tx_start_req;
	logic         envelope_input_pin;
	rftxm_cfg_s   cfg;
	logic [15:0]  crc_result_regs;
	logic         tx_start;
	logic         envelope_n;
	logic         envelope_activity_event;
	logic         irq;
	int           fail_count = 0;
	int           samples_checked = 0;
	int           cycles = 0;
	int           ev_cnt = 0;
	logic [31:0]  rd;
	logic [15:0]  presets [4];

	rftxm_regs rftxm_regs_i (
		.clk                     (clk),
		.reset_n                 (reset_n),
		.av_req                  (av_req),
		.av_rsp                  (av_rsp),
		.rf_comm_active          (rf_comm_active),
		.rf_field_on             (rf_field_on),
		.auto_crc_preset         (auto_crc_preset),
		.crc_raw_result          (crc_raw_result),
		.tx_start_req            (tx_start_req),
		.envelope_input_pin      (envelope_input_pin),
		.cfg                     (cfg),
		.crc_result_regs         (crc_result_regs),
		.tx_start                (tx_start),
		.envelope_n              (envelope_n),
		.envelope_activity_event (envelope_activity_event),
		.irq                     (irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic stop_test();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		int n;
		n = 0;
		@(posedge clk);
		av_req.address   <= addr;
		av_req.read      <= ~wr;
		av_req.write     <= wr;
		av_req.writedata <= {24'h0, data};
		do begin
			@(posedge clk);
			n++;
		end while (av_rsp.waitrequest !== 1'b0 && n < 100);
		rd = av_rsp.readdata;
		av_req.read  <= 1'b0;
		av_req.write <= 1'b0;
		chk("answer", 32'(n < 100), 32'h1);
	endtask

	task automatic rc(input string name, input logic [7:0] addr, input logic [7:0] exp);
		bus(1'b0, addr, 8'h00);
		chk(name, rd, {24'h0, exp});
	endtask

	// Let registered outputs settle, sample off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (envelope_activity_event === 1'b1) begin
			ev_cnt++;
		end
		if (cycles == 3000) begin
			fail_count++;
			stop_test();
		end
	end

	initial begin
		presets = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
		reset_n = 1'b0;
		av_req = '0;
		av_req.byteenable = 4'h1;
		rf_comm_active = 1'b0;
		rf_field_on = 1'b0;
		auto_crc_preset = 16'h0000;
		crc_raw_result = 16'h0000;
		tx_start_req = 1'b0;
		envelope_input_pin = 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		rc("rsvd_a", 8'h3c, 8'h00);
		rc("rsvd_b", 8'h40, 8'h00);
		rc("mode", 8'h44, 8'h2b);
		rc("txmode", 8'h48, 8'h00);
		wt(1);
		chk("start_value", cfg.crc_start_value, 32'hffff);
		bus(1'b1, 8'h3c, 8'hff);
		rc("rsvd_a", 8'h3c, 8'h00);
		bus(1'b1, 8'h40, 8'hff);
		rc("rsvd_b", 8'h40, 8'h00);
		bus(1'b1, 8'h14, 8'hff);
		rc("unmapped", 8'h14, 8'h00);
		bus(1'b1, 8'h44, 8'hff);
		rc("mode", 8'h44, 8'hab);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h44, 8'h08 | 8'(i));
			wt(2);
			chk("start_value", cfg.crc_start_value, presets[i]);
		end
		@(posedge clk);
		auto_crc_preset <= 16'h1234;
		rf_comm_active <= 1'b1;
		wt(2);
		chk("start_value", cfg.crc_start_value, 32'h1234);
		@(posedge clk);
		rf_comm_active <= 1'b0;
		crc_raw_result <= 16'h0180;
		bus(1'b1, 8'h44, 8'h88);
		wt(2);
		chk("crc_result", crc_result_regs, 32'h8001);
		chk("bit_order", cfg.crc_bit_order_msb, 32'h1);
		@(posedge clk);
		rf_comm_active <= 1'b1;
		wt(2);
		chk("crc_result", crc_result_regs, 32'h0180);
		chk("bit_order", cfg.crc_bit_order_msb, 32'h0);
		@(posedge clk);
		rf_comm_active <= 1'b0;
		bus(1'b1, 8'h44, 8'h28);
		@(posedge clk);
		tx_start_req <= 1'b1;
		wt(2);
		chk("tx_start", tx_start, 32'h0);
		chk("needs_field", cfg.tx_needs_field, 32'h1);
		chk("polarity", cfg.envelope_in_polarity, 32'h1);
		@(posedge clk);
		rf_field_on <= 1'b1;
		wt(2);
		chk("tx_start", tx_start, 32'h1);
		@(posedge clk);
		tx_start_req <= 1'b0;
		envelope_input_pin <= 1'b1;
		wt(2);
		chk("envelope", envelope_n, 32'h0);
		@(posedge clk);
		envelope_input_pin <= 1'b0;
		wt(2);
		chk("envelope", envelope_n, 32'h1);
		// Polarity change drives the event and the interrupt path
		bus(1'b1, 8'h84, 8'h03);
		bus(1'b1, 8'h88, 8'h01);
		rc("irq_en", 8'h88, 8'h01);
		bus(1'b1, 8'h44, 8'h20);
		wt(2);
		chk("events", ev_cnt, 32'h1);
		chk("envelope", envelope_n, 32'h0);
		chk("polarity", cfg.envelope_in_polarity, 32'h0);
		rc("irq_sts", 8'h80, 8'h01);
		chk("irq", irq, 32'h1);
		bus(1'b1, 8'h88, 8'h00);
		wt(2);
		chk("irq", irq, 32'h0);
		bus(1'b1, 8'h44, 8'h20);
		wt(2);
		chk("events", ev_cnt, 32'h1);
		bus(1'b1, 8'h88, 8'h01);
		wt(2);
		chk("irq", irq, 32'h1);
		bus(1'b1, 8'h84, 8'h01);
		wt(2);
		chk("irq", irq, 32'h0);
		rc("irq_sts", 8'h80, 8'h00);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h48, 8'h88 | 8'(i << 4));
			rc("txmode", 8'h48, 8'h88 | 8'(i << 4));
			wt(2);
			chk("rate", cfg.tx_bit_rate_sel, 32'(i));
			chk("invert", cfg.tx_modulation_invert, 32'h1);
			chk("append", cfg.tx_crc_append_en, 32'h1);
		end
		bus(1'b1, 8'h48, 8'h40);
		rc("txmode", 8'h48, 8'h30);
		wt(2);
		chk("append", cfg.tx_crc_append_en, 32'h1);
		bus(1'b1, 8'h48, 8'h07);
		rc("txmode", 8'h48, 8'h00);
		wt(2);
		chk("append", cfg.tx_crc_append_en, 32'h0);
		chk("invert", cfg.tx_modulation_invert, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
